//--- rtl/smsc_pkg.sv
package smsc_pkg;
  // standby sequencer states
  typedef enum logic [1:0]
  {
    SMSC_RUN  = 2'b00,  // cpu executing
    SMSC_STOP = 2'b01,  // deep standby, clocks gated
    SMSC_WAIT = 2'b10   // halt-like stabilization wait
  } smsc_state_t;

  // width of the stabilization time select code
  localparam int SMSC_STAB_SEL_W = 3;
  // reset value of the stabilization time select register
  localparam logic [SMSC_STAB_SEL_W-1:0] SMSC_STAB_SEL_RST = 3'h5;
  // shortest stabilization wait, as a power of two of cycles
  localparam int SMSC_WAIT_BASE_LOG2 = 11;
  // counter width to hold the longest wait
  localparam int SMSC_WAIT_CNT_W = 20;
  // register bus
  localparam int SMSC_ADDR_W = 4;
  localparam logic [SMSC_ADDR_W-1:0] SMSC_REG_CTRL = 4'h0;
  localparam logic [SMSC_ADDR_W-1:0] SMSC_REG_SEL = 4'h1;
  localparam logic [SMSC_ADDR_W-1:0] SMSC_REG_STAT = 4'h2;
  localparam logic [SMSC_ADDR_W-1:0] SMSC_REG_STAB = 4'h3;
  // control register fields
  localparam int SMSC_CTRL_WDT_SWSTOP = 0;   // option: low-speed osc sw stop
  localparam int SMSC_CTRL_RL_EN = 1;        // low-speed oscillator run
  localparam int SMSC_CTRL_XT_EN = 2;        // sub crystal run
  localparam int SMSC_CTRL_EXT_SUB = 3;      // external subsystem clock used
  localparam logic [7:0] SMSC_CTRL_RST = 8'h02;
  // count clock select fields (one bit each)
  localparam int SMSC_SEL_A_EXT = 0;   // counter a on its external input
  localparam int SMSC_SEL_B_EXT = 1;   // counter b on its external input
  localparam int SMSC_SEL_ITA_CA = 2;  // interval timer a on counter a out
  localparam int SMSC_SEL_ITB_RL = 3;  // interval timer b on low-speed clk
  localparam int SMSC_SEL_WT_SUB = 4;  // watch timer on subsystem clock
  localparam int SMSC_SEL_CO_SUB = 5;  // clock output on subsystem clock
  localparam int SMSC_SEL_A_RUN = 6;   // counter a enabled
  localparam logic [7:0] SMSC_SEL_RST = 8'h00;

  // clock enables handed to the peripherals
  typedef struct packed
  {
    logic cpu;
    logic main_osc;
    logic ext_main;
    logic flash;
    logic counter16;
    logic buzzer;
    logic counter_a;
    logic counter_b;
    logic interval_timer_a;
    logic interval_timer_b;
    logic watch_timer;
    logic clock_out;
    logic watchdog;
    logic sub_crystal_clock;
    logic low_speed_internal_clock;
  } smsc_gate_t;
endpackage

//--- rtl/smsc_stop_ctrl.sv
`timescale 1ns/10ps
module smsc_stop_ctrl
(
  // clock and reset
  input  wire logic                               sys_clk,
  input  wire logic                               rst_b,
  // cpu handshake
  input  wire logic                               stop_exec,
  input  wire logic                               cpu_on_main,
  input  wire logic                               irq_pending,
  input  wire logic                               ext_sub_active,
  // register port
  input  wire logic [smsc_pkg::SMSC_ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]                         reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [7:0]                         reg_rdata,
  // state and clock enables
  output logic                                    in_standby,
  output smsc_pkg::smsc_gate_t                    gate
);
  import smsc_pkg::*;

  smsc_state_t                state;        // sequencer state
  smsc_state_t                next_state;   // next sequencer state
  logic [7:0]                 ctrl;         // oscillator / option bits
  logic [7:0]                 sel;          // count clock selections
  logic [SMSC_STAB_SEL_W-1:0] stabilization_time_select; // wait code
  logic [SMSC_WAIT_CNT_W-1:0] wait_cnt;     // stabilization counter
  logic [SMSC_WAIT_CNT_W-1:0] wait_len;     // selected wait length
  smsc_gate_t                 next_gate;    // combinational enables

  // bus decode
  wire wr_ctrl = reg_wr && (reg_addr == SMSC_REG_CTRL);
  wire wr_sel  = reg_wr && (reg_addr == SMSC_REG_SEL);
  wire wr_stab = reg_wr && (reg_addr == SMSC_REG_STAB);
  wire stop_ok = stop_exec && cpu_on_main;
  wire go_stop = (state == SMSC_RUN) && stop_ok && !irq_pending;
  wire go_wait = (state == SMSC_RUN) && stop_ok && irq_pending;
  wire wait_done = (state == SMSC_WAIT) && (wait_cnt == wait_len);
  wire standby = (next_state == SMSC_STOP);
  wire ctr_a_on = sel[SMSC_SEL_A_RUN] && sel[SMSC_SEL_A_EXT];
  wire sub_on = ctrl[SMSC_CTRL_EXT_SUB] ? ext_sub_active
                                        : ctrl[SMSC_CTRL_XT_EN];
  wire [7:0] stat_word = {6'h00, state};
  wire [7:0] rd_mux = (reg_addr == SMSC_REG_CTRL) ? ctrl :
                      (reg_addr == SMSC_REG_SEL)  ? sel :
                      (reg_addr == SMSC_REG_STAT) ? stat_word :
                      (reg_addr == SMSC_REG_STAB) ?
                        {5'h00, stabilization_time_select} : 8'h00;

  // wait length doubles per select step; reason: one shift, no table
  assign wait_len = SMSC_WAIT_CNT_W'(
    (1 << (SMSC_WAIT_BASE_LOG2 + int'(stabilization_time_select))) - 1);

  // the counter must hold the longest selectable wait, else waits wrap
  if (SMSC_WAIT_BASE_LOG2 + (1 << SMSC_STAB_SEL_W) - 1 > SMSC_WAIT_CNT_W)
  begin
    $error("wait counter narrower than longest wait");
  end

  // next state; interrupt in standby also releases via wait
  always_comb
  begin
    next_state = state;
    unique case (state)
      SMSC_RUN:
      begin
        if (go_stop)
          next_state = SMSC_STOP;
        else if (go_wait)
          next_state = SMSC_WAIT;
      end
      SMSC_STOP:
      begin
        if (irq_pending)
          next_state = SMSC_WAIT;
      end
      SMSC_WAIT:
      begin
        if (wait_done)
          next_state = SMSC_RUN;
      end
      default:
        next_state = SMSC_RUN;
    endcase
  end

  // clock enables; ram and port latches are never reset here
  always_comb
  begin
    next_gate = '1;
    next_gate.sub_crystal_clock = sub_on;
    next_gate.low_speed_internal_clock = ctrl[SMSC_CTRL_RL_EN];
    next_gate.counter_a = sel[SMSC_SEL_A_RUN];
    next_gate.watchdog = !(ctrl[SMSC_CTRL_WDT_SWSTOP] &&
                           !ctrl[SMSC_CTRL_RL_EN]);
    if (standby || next_state == SMSC_WAIT)
      next_gate.cpu = 1'b0;
    if (standby)
    begin
      next_gate.main_osc = 1'b0;
      next_gate.ext_main = 1'b0;
      next_gate.flash = 1'b0;
      next_gate.counter16 = 1'b0;
      next_gate.buzzer = 1'b0;
      next_gate.counter_a = ctr_a_on;
      next_gate.counter_b = sel[SMSC_SEL_B_EXT];
      next_gate.interval_timer_a = sel[SMSC_SEL_ITA_CA] &&
                                   ctr_a_on;
      next_gate.interval_timer_b = sel[SMSC_SEL_ITB_RL] &&
                                   ctrl[SMSC_CTRL_RL_EN];
      next_gate.watch_timer = sel[SMSC_SEL_WT_SUB] && sub_on;
      next_gate.clock_out = sel[SMSC_SEL_CO_SUB] && sub_on;
      next_gate.watchdog = !ctrl[SMSC_CTRL_WDT_SWSTOP] ||
                           ctrl[SMSC_CTRL_RL_EN];
    end
  end

  // state, counter and outputs
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= SMSC_RUN;
      wait_cnt <= '0;
      in_standby <= 1'b0;
      gate <= '1;
    end
    else
    begin
      state <= next_state;
      wait_cnt <= (next_state == SMSC_WAIT && state == SMSC_WAIT) ?
                  wait_cnt + 1'b1 : '0;
      in_standby <= standby;
      gate <= next_gate;
    end
  end

  // registers; writes are taken in every state, standby included
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl <= SMSC_CTRL_RST;
      sel <= SMSC_SEL_RST;
      stabilization_time_select <= SMSC_STAB_SEL_RST;
      reg_rdata <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= {4'h0, reg_wdata[3:0]};
      if (wr_sel)
        sel <= {1'b0, reg_wdata[6:0]};
      if (wr_stab)
        stabilization_time_select <= reg_wdata[SMSC_STAB_SEL_W-1:0];
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // checks
  property p_entry;
    @(posedge sys_clk) disable iff (!rst_b)
    (state == SMSC_RUN && !stop_ok) |=> state == SMSC_RUN;
  endproperty
  a_entry: assert property (p_entry) else $error("stray entry");

  property p_main;
    @(posedge sys_clk) disable iff (!rst_b)
    (stop_exec && !cpu_on_main && state == SMSC_RUN) |=> state == SMSC_RUN;
  endproperty
  a_main: assert property (p_main) else $error("entry off main");

  property p_wait;
    @(posedge sys_clk) disable iff (!rst_b)
    go_wait |=> state == SMSC_WAIT ##1 (state == SMSC_WAIT)[*1];
  endproperty
  a_wait: assert property (p_wait) else $error("no halt wait");

  property p_cpu;
    @(posedge sys_clk) disable iff (!rst_b)
    go_stop |=> !gate.cpu && in_standby;
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu clock on");

  property p_osc;
    @(posedge sys_clk) disable iff (!rst_b)
    in_standby |-> !gate.main_osc && !gate.ext_main;
  endproperty
  a_osc: assert property (p_osc) else $error("main osc on");

  property p_stop9;
    @(posedge sys_clk) disable iff (!rst_b)
    in_standby |-> !gate.flash && !gate.counter16 && !gate.buzzer;
  endproperty
  a_stop9: assert property (p_stop9) else $error("periph on");

  property p_cta;
    @(posedge sys_clk) disable iff (!rst_b)
    in_standby |-> (gate.counter_a == $past(ctr_a_on));
  endproperty
  a_cta: assert property (p_cta) else $error("counter a gate");

  property p_ita;
    @(posedge sys_clk) disable iff (!rst_b)
    (in_standby && gate.interval_timer_a) |-> gate.counter_a;
  endproperty
  a_ita: assert property (p_ita) else $error("itimer a gate");

  property p_wt;
    @(posedge sys_clk) disable iff (!rst_b)
    (in_standby && gate.watch_timer) |-> gate.sub_crystal_clock;
  endproperty
  a_wt: assert property (p_wt) else $error("watch gate");

  property p_wdt;
    @(posedge sys_clk) disable iff (!rst_b)
    (in_standby && !$past(ctrl[SMSC_CTRL_WDT_SWSTOP])) |-> gate.watchdog;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog off");

  property p_release;
    @(posedge sys_clk) disable iff (!rst_b)
    (state == SMSC_WAIT && wait_done) |=> state == SMSC_RUN && gate.cpu;
  endproperty
  a_release: assert property (p_release) else $error("no wake");

  // standby is left only through a pending interrupt; the cpu clock
  // must stay cut for every cycle of it, not just the first
  property p_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    (state == SMSC_STOP && !irq_pending) |=> state == SMSC_STOP && !gate.cpu;
  endproperty
  a_hold: assert property (p_hold) else $error("standby left");

  // counter b keeps its enable only when its external input counts;
  // the selection seen is the one in force when the gate was built
  property p_ctb;
    @(posedge sys_clk) disable iff (!rst_b)
    in_standby |-> (gate.counter_b == $past(sel[SMSC_SEL_B_EXT]));
  endproperty
  a_ctb: assert property (p_ctb) else $error("counter b gate");

  // interval timer b runs only from a low-speed oscillator left running;
  // selecting it while the oscillator is off gives no clock at all
  property p_itb;
    @(posedge sys_clk) disable iff (!rst_b)
    in_standby |-> (gate.interval_timer_b ==
                    ($past(sel[SMSC_SEL_ITB_RL]) &&
                     $past(ctrl[SMSC_CTRL_RL_EN])));
  endproperty
  a_itb: assert property (p_itb) else $error("itimer b gate");

  // the low-speed oscillator follows its run bit, one cycle late
  property p_rl;
    @(posedge sys_clk) disable iff (!rst_b)
    in_standby |->
      (gate.low_speed_internal_clock == $past(ctrl[SMSC_CTRL_RL_EN]));
  endproperty
  a_rl: assert property (p_rl) else $error("low-speed osc");

  // sub clock: an external one follows its pin, the crystal its run bit;
  // the pin is not filtered, so a stalled source drops the domain at once
  property p_sub;
    @(posedge sys_clk) disable iff (!rst_b)
    in_standby |->
      (gate.sub_crystal_clock == ($past(ctrl[SMSC_CTRL_EXT_SUB]) ?
                                  $past(ext_sub_active) :
                                  $past(ctrl[SMSC_CTRL_XT_EN])));
  endproperty
  a_sub: assert property (p_sub) else $error("sub clk");

  // clock output survives only on a live sub clock
  property p_co;
    @(posedge sys_clk) disable iff (!rst_b)
    in_standby |->
      (gate.clock_out == ($past(sel[SMSC_SEL_CO_SUB]) &&
                          gate.sub_crystal_clock));
  endproperty
  a_co: assert property (p_co) else $error("clock out gate");

  // main scenarios: entry, collapse, release, refusal and wake request

  c_stop: cover property (@(posedge sys_clk) disable iff (!rst_b) go_stop);
  c_wait: cover property (@(posedge sys_clk) disable iff (!rst_b) go_wait);
  c_done: cover property (@(posedge sys_clk) disable iff (!rst_b) wait_done);
  c_refuse: cover property (@(posedge sys_clk) disable iff (!rst_b)
    stop_exec && !cpu_on_main && state == SMSC_RUN);
  c_wake: cover property (@(posedge sys_clk) disable iff (!rst_b)
    state == SMSC_STOP && irq_pending);
endmodule

//--- verification/smsc_periph_model.sv
`timescale 1ns/10ps
// far side: cpu and ram that run only on the gated cpu enable
module smsc_periph_model
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // clock enables from the sequencer
  input  wire smsc_pkg::smsc_gate_t gate,
  // activity seen by the bench
  output logic [15:0]               cpu_ticks,
  output logic [7:0]                ram_word
);
  import smsc_pkg::*;
  // cpu steps only while its clock is enabled; frozen while gated
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cpu_ticks <= 16'h0000;
    else if (gate.cpu)
      cpu_ticks <= cpu_ticks + 16'h0001;
  end
  // ram word is written by the running cpu only, so standby keeps it
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ram_word <= 8'h00;
    else if (gate.cpu)
      ram_word <= cpu_ticks[7:0];
  end
endmodule

//--- verification/tb.sv
`timescale 1ns/10ps
// entry, refusal, per-peripheral gating and timed wake-up
module tb;
  import smsc_pkg::*;
  // bookkeeping
  int err_total = 0;
  int n_tests   = 0;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
  // design inputs, all defined at time zero
  logic                   sys_clk        = 1'b0;
  logic                   rst_b          = 1'b0;
  logic                   stop_exec      = 1'b0;
  logic                   cpu_on_main    = 1'b1;
  logic                   irq_pending    = 1'b0;
  logic                   ext_sub_active = 1'b0;
  logic [SMSC_ADDR_W-1:0] reg_addr       = 4'h0;
  logic [7:0]             reg_wdata      = 8'h00;
  logic                   reg_wr         = 1'b0;
  logic                   reg_rd         = 1'b0;
  // observed values
  logic [7:0]             reg_rdata;
  logic                   in_standby;
  smsc_gate_t             gate;
  logic [15:0]            cpu_ticks;
  logic [7:0]             ram_word;
  logic [23:0]            held;
  // 125 MHz
  always #4 sys_clk = ~sys_clk;
  smsc_stop_ctrl smsc_stop_ctrl_inst (.sys_clk, .rst_b, .stop_exec,
    .cpu_on_main, .irq_pending, .ext_sub_active, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .in_standby, .gate);
  smsc_periph_model smsc_periph_model_inst (.sys_clk, .rst_b, .gate,
    .cpu_ticks, .ram_word);
  // single exit point of the run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  // read: data only stands in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // one stop instruction, outputs sampled once settled
  task automatic stop_pulse();
    @(posedge sys_clk);
    stop_exec <= 1'b1;
    @(posedge sys_clk);
    stop_exec <= 1'b0;
    #1;
  endtask
  // bounded wait for the cpu clock to come back
  task automatic wake(input int lo, input int hi);
    int n = 0;
    while (gate.cpu !== 1'b1 && n < 5000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    `CHK(in_standby, 1'b0)
    if (n >= 5000)
      finish_test();
    @(posedge sys_clk);
    irq_pending <= 1'b0;
  endtask
  // reset values, idle stays out of standby
  task automatic t_reset();
    logic [7:0] d;
    rd(SMSC_REG_CTRL, d);
    `CHK(d, SMSC_CTRL_RST)
    rd(SMSC_REG_STAB, d);
    `CHK(d, {5'h00, SMSC_STAB_SEL_RST})
    rd(4'hf, d);
    `CHK(d, 8'h00)
    `CHK(in_standby, 1'b0)
    wr(SMSC_REG_STAB, 8'h00);
    $display("done reset");
  endtask
  // stop while cpu is not on the main clock is ignored
  task automatic t_refuse();
    cpu_on_main <= 1'b0;
    stop_pulse();
    `CHK({in_standby, gate.cpu}, 2'b01)
    @(posedge sys_clk);
    cpu_on_main <= 1'b1;
    $display("done refuse");
  endtask
  // everything selectable kept alive; cpu and ram frozen
  task automatic t_keep();
    wr(SMSC_REG_CTRL, 8'h06);
    wr(SMSC_REG_SEL, 8'h7f);
    stop_pulse();
    held = {cpu_ticks, ram_word};
    `CHK(in_standby, 1'b1)
    `CHK(gate, 15'h01ff)
    repeat (20) @(posedge sys_clk);
    `CHK({cpu_ticks, ram_word}, held)
    irq_pending <= 1'b1;
    wake(2045, 2055);
    $display("done keep");
  endtask
  // counter a and itimer a selected without counter a external input, option lets low-speed osc stop; longer wait
  task automatic t_cut();
    wr(SMSC_REG_CTRL, 8'h01);
    wr(SMSC_REG_SEL, 8'h44);
    wr(SMSC_REG_STAB, 8'h01);
    stop_pulse();
    `CHK(gate, 15'h0000)
    @(posedge sys_clk);
    irq_pending <= 1'b1;
    wake(4093, 4103);
    wr(SMSC_REG_STAB, 8'h00);
    $display("done cut");
  endtask
  // external subsystem clock presence follows its pin
  task automatic t_extsub();
    wr(SMSC_REG_CTRL, 8'h0a);
    wr(SMSC_REG_SEL, 8'h30);
    ext_sub_active <= 1'b1;
    stop_pulse();
    `CHK({gate.watch_timer, gate.clock_out}, 2'b11)
    `CHK(gate.watchdog, 1'b1)
    @(posedge sys_clk);
    ext_sub_active <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK({gate.watch_timer, gate.clock_out}, 2'b00)
    @(posedge sys_clk);
    irq_pending <= 1'b1;
    wake(2045, 2055);
    $display("done extsub");
  endtask
  // pending interrupt at stop collapses into the timed wait
  task automatic t_irq_at_stop();
    logic [7:0] d;
    @(posedge sys_clk);
    irq_pending <= 1'b1;
    stop_pulse();
    `CHK({in_standby, gate.cpu}, 2'b00)
    rd(SMSC_REG_STAT, d);
    `CHK(d, {6'h00, SMSC_WAIT})
    wake(2040, 2055);
    $display("done irq at stop");
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_refuse();
    t_keep();
    t_cut();
    t_extsub();
    t_irq_at_stop();
    finish_test();
  end
endmodule
